/* File: hw/uer_pkg.sv */
// Package for the endpoint receive status and buffer map block.
// Assumes a 32-bit APB register port and a single clock domain.
package uer_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_RX_CSR      = 8'h00;
    localparam logic [7:0]  OFS_FIFO_ADDR   = 8'h04;
    localparam logic [7:0]  OFS_CTRL        = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT    = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h10;
    localparam logic [7:0]  OFS_PAYLOAD     = 8'h14;
    localparam int          BIT_ERR         = 18;
    localparam int          BIT_FULL        = 17;
    localparam int          BIT_RDY         = 16;
    localparam int          PACKET_MULTIPLIER_LSB        = 11;
    localparam int          PACKET_MULTIPLIER_W          = 5;
    localparam int          MAXP_W          = 11;
    localparam int          FAD_W           = 13;
    localparam int          RXFAD_LSB       = 16;
    localparam int          UNIT_SHIFT      = 3;
    localparam logic [1:0]  NODATA_LIMIT    = 2'h3;
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_RDY         = 0;
    localparam int          IRQ_ERR         = 1;
    localparam int          IRQ_FULL        = 2;
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;
    localparam int          PAYLOAD_W       = 17;

    typedef enum logic [1:0] {XFER_BULK, XFER_INTR, XFER_ISO} uer_xfer_type;
    typedef enum logic [1:0] {APB_IDLE, APB_ACCESS} uer_apb_state_type;
endpackage

/* File: hw/uer_ev_if.sv */
// Event bundle between endpoint core and interrupt unit.
// Assumes one clock; events are single-cycle pulses.
`timescale 1ns/1ns
interface uer_ev_if;
    logic [2:0] evPulse;
    logic [2:0] statusBits;
    logic       statusRead;
    modport src (output evPulse, output statusRead, input statusBits);
    modport dst (input evPulse, input statusRead, output statusBits);
endinterface

/* File: hw/uer_irq.sv */
// Sticky interrupt status with mask; a status read clears it.
// Assumes statusRead pulses once, at the edge where the status word is captured.
`timescale 1ns/1ns
module uer_irq
    import uer_pkg::*;
#(
    parameter int W = IRQ_W
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    uer_ev_if.dst     ev,
    input  wire logic [W-1:0] mask,
    output logic      irq
);
    typedef struct packed {
        logic [W-1:0] stat;
    } uer_irq_type;
    uer_irq_type st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // Set beats the read clear so no event is lost
        if (ev.statusRead) begin
            nxt_st.stat = '0;
        end
        nxt_st.stat = nxt_st.stat | ev.evPulse;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ev.statusBits = st_ff.stat;
    assign irq           = |(st_ff.stat & mask);

    chk_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
        (|(ev.evPulse & mask)) |=> (irq || mask != $past(mask)))
        else $error("unmasked event did not raise irq");
    chk_sticky_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ev.evPulse[0]) |=> st_ff.stat[0]) else $error("event not kept");
endmodule

/* File: hw/uer_payload.sv */
// Payload size from max payload and multiplier.
// Assumes inputs are stable register fields.
`timescale 1ns/1ns
module uer_payload
    import uer_pkg::*;
(
    input  wire logic [MAXP_W-1:0]    maxPayload,
    input  wire logic [PACKET_MULTIPLIER_W-1:0]    packet_multiplier,
    input  wire logic                 useMult,
    output logic      [PAYLOAD_W-1:0] payload
);
    logic [PAYLOAD_W-1:0] factor;
    always_comb begin
        factor  = PAYLOAD_W'(packet_multiplier) + PAYLOAD_W'(1);
        payload = useMult ? PAYLOAD_W'(PAYLOAD_W'(maxPayload) * factor)
                          : PAYLOAD_W'(maxPayload);
    end
endmodule

/* File: hw/uer_top.sv */
// Endpoint receive status, payload sizing and FIFO start map over APB.
// Assumes the USB core gives receive events as one-cycle pulses.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
module uer_top
    import uer_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [uer_pkg::ADDR_W-1:0] paddr,
    input  wire logic [uer_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [uer_pkg::DATA_W-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      rxPacketDone,
    input  wire logic                      rxPacketDropped,
    input  wire logic                      rxAttemptNoData,
    input  wire logic                      rxAttemptData,
    input  wire logic                      rxFifoNoRoom,
    output logic      [15:0]               rxBufferStartByte,
    output logic      [15:0]               txBufferStartByte,
    output logic      [uer_pkg::PAYLOAD_W-1:0] payloadSize,
    output logic      [uer_pkg::PACKET_MULTIPLIER_W-1:0] txnPerMicroframe,
    output logic                           rxPacketWaiting,
    output logic                           irq
);
    import uer_pkg::*;

    // Control word: bit0 host mode, bits 2:1 transfer type, bit3 high speed
    typedef struct packed {
        uer_apb_state_type     apb;
        logic [DATA_W-1:0]     rdata;
        logic                  slvErr;
        logic                  overrunErr;
        logic                  rdyFlag;
        logic [PACKET_MULTIPLIER_W-1:0]     packet_multiplier;
        logic [MAXP_W-1:0]     maxp;
        logic [FAD_W-1:0]      rxStart;
        logic [FAD_W-1:0]      txStart;
        logic                  hostMode;
        uer_xfer_type          xfer;
        logic                  highSpeed;
        logic                  splitBulk;
        logic [IRQ_W-1:0]      mask;
        logic [1:0]            missCnt;
    } uer_top_type;

    uer_top_type st_ff, nxt_st;
    uer_ev_if    evBus();
    logic        wrDone;
    logic        rdStart;
    logic        csrWordFullPrev;
    logic        errAllowed;
    logic        setErr;
    logic [DATA_W-1:0] csrWord;
    logic [DATA_W-1:0] fadWord;

    assign wrDone = psel && penable && pwrite && st_ff.apb == APB_ACCESS;
    // Reads are captured at the setup edge so prdata stands through the access cycle
    assign rdStart = psel && !penable && !pwrite && st_ff.apb == APB_IDLE;

    // Error bit is meaningful only for the mode's allowed transfer types
    always_comb begin
        if (st_ff.hostMode) begin
            errAllowed = st_ff.xfer != XFER_ISO;
        end else begin
            errAllowed = st_ff.xfer == XFER_ISO;
        end
    end

    always_comb begin
        setErr = 1'b0;
        if (!st_ff.hostMode) begin
            setErr = rxPacketDropped && errAllowed;
        end else if (errAllowed && rxAttemptNoData && st_ff.missCnt == NODATA_LIMIT - 2'h1) begin
            setErr = 1'b1;
        end
    end

    always_comb begin
        csrWord                              = RST_WORD;
        csrWord[BIT_ERR]                     = st_ff.overrunErr && errAllowed;
        csrWord[BIT_FULL]                    = rxFifoNoRoom;
        csrWord[BIT_RDY]                     = st_ff.rdyFlag;
        csrWord[PACKET_MULTIPLIER_LSB +: PACKET_MULTIPLIER_W]          = st_ff.packet_multiplier;
        csrWord[MAXP_W-1:0]                  = st_ff.maxp;
        fadWord                              = RST_WORD;
        fadWord[RXFAD_LSB +: FAD_W]          = st_ff.rxStart;
        fadWord[FAD_W-1:0]                   = st_ff.txStart;
    end

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.slvErr = 1'b0;
        case (st_ff.apb)
            APB_IDLE: begin
                if (psel && !penable) begin
                    nxt_st.apb = APB_ACCESS;
                end
            end
            APB_ACCESS: begin
                nxt_st.apb = APB_IDLE;
            end
            default: begin
                nxt_st.apb = APB_IDLE;
            end
        endcase
        // Miss counter restarts on any data, on a no-data error, or outside host mode
        if (!st_ff.hostMode || rxAttemptData || setErr) begin
            nxt_st.missCnt = '0;
        end else if (rxAttemptNoData) begin
            nxt_st.missCnt = st_ff.missCnt + 2'h1;
        end
        if (wrDone) begin
            case (paddr)
                OFS_RX_CSR: begin
                    // Writing one leaves flags alone; only zero clears
                    if (pstrb[2] && !pwdata[BIT_ERR]) begin
                        nxt_st.overrunErr = 1'b0;
                    end
                    if (pstrb[2] && !pwdata[BIT_RDY]) begin
                        nxt_st.rdyFlag = 1'b0;
                    end
                    if (pstrb[1]) begin
                        nxt_st.packet_multiplier          = pwdata[PACKET_MULTIPLIER_LSB +: PACKET_MULTIPLIER_W];
                        nxt_st.maxp[10:8]    = pwdata[10:8];
                    end
                    if (pstrb[0]) begin
                        nxt_st.maxp[7:0] = pwdata[7:0];
                    end
                end
                OFS_FIFO_ADDR: begin
                    if (pstrb[3]) nxt_st.rxStart[12:8] = pwdata[28:24];
                    if (pstrb[2]) nxt_st.rxStart[7:0]  = pwdata[23:16];
                    if (pstrb[1]) nxt_st.txStart[12:8] = pwdata[12:8];
                    if (pstrb[0]) nxt_st.txStart[7:0]  = pwdata[7:0];
                end
                OFS_CTRL: begin
                    if (pstrb[0]) begin
                        nxt_st.hostMode  = pwdata[0];
                        nxt_st.xfer      = uer_xfer_type'(pwdata[2:1]);
                        nxt_st.highSpeed = pwdata[3];
                        nxt_st.splitBulk = pwdata[4];
                    end
                end
                OFS_IRQ_MASK: begin
                    if (pstrb[0]) nxt_st.mask = pwdata[IRQ_W-1:0];
                end
                OFS_IRQ_STAT, OFS_PAYLOAD: begin
                end
                default: begin
                    nxt_st.slvErr = 1'b1;
                end
            endcase
        end
        // Hardware set wins over a same-cycle clear
        if (setErr) begin
            nxt_st.overrunErr = 1'b1;
        end
        if (rxPacketDone) begin
            nxt_st.rdyFlag = 1'b1;
        end
        if (rdStart) begin
            case (paddr)
                OFS_RX_CSR:    nxt_st.rdata = csrWord;
                OFS_FIFO_ADDR: nxt_st.rdata = fadWord;
                OFS_CTRL:      nxt_st.rdata = DATA_W'({st_ff.splitBulk, st_ff.highSpeed,
                                                       st_ff.xfer, st_ff.hostMode});
                OFS_IRQ_STAT:  nxt_st.rdata = DATA_W'(evBus.statusBits);
                OFS_IRQ_MASK:  nxt_st.rdata = DATA_W'(st_ff.mask);
                OFS_PAYLOAD:   nxt_st.rdata = DATA_W'(payloadSize);
                default: begin
                    nxt_st.rdata  = RST_WORD;
                    nxt_st.slvErr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Zero wait: read data was taken at the setup edge, so it is valid with pready
    assign pready  = st_ff.apb == APB_ACCESS;
    assign prdata  = st_ff.rdata;
    assign pslverr = 1'b0;

    // Status clear shares the capture edge, so no event slips between read and clear
    assign evBus.evPulse    = {rxFifoNoRoom && !csrWordFullPrev, setErr, rxPacketDone};
    assign evBus.statusRead = rdStart && paddr == OFS_IRQ_STAT;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            csrWordFullPrev <= 1'b0;
        end else begin
            csrWordFullPrev <= rxFifoNoRoom;
        end
    end

    uer_irq u_irq (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .ev      (evBus),
        .mask    (st_ff.mask),
        .irq     (irq)
    );

    // Bulk split or periodic endpoints use the multiplier
    uer_payload u_payload (
        .maxPayload (st_ff.maxp),
        .packet_multiplier       (st_ff.packet_multiplier),
        .useMult    (st_ff.xfer != XFER_BULK || st_ff.splitBulk),
        .payload    (payloadSize)
    );

    // High-speed periodic: field gives transactions per microframe
    assign txnPerMicroframe  = (st_ff.highSpeed && st_ff.xfer != XFER_BULK)
                               ? st_ff.packet_multiplier : PACKET_MULTIPLIER_W'(1);
    assign rxBufferStartByte = {st_ff.rxStart, UNIT_SHIFT'(0)};
    assign txBufferStartByte = {st_ff.txStart, UNIT_SHIFT'(0)};
    assign rxPacketWaiting   = st_ff.rdyFlag;

    chk_ready_set: assert property (@(posedge ref_clk) disable iff (!resetn)
        rxPacketDone |=> st_ff.rdyFlag) else $error("ready flag not set");
    chk_err_bulk_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!st_ff.hostMode && st_ff.xfer == XFER_BULK) |-> !csrWord[BIT_ERR])
        else $error("overrun visible on bulk");
    chk_err_iso_host: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_ff.hostMode && st_ff.xfer == XFER_ISO) |-> !csrWord[BIT_ERR])
        else $error("no-data error visible on iso");
    chk_overrun_set: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!st_ff.hostMode && st_ff.xfer == XFER_ISO && rxPacketDropped) |=> st_ff.overrunErr)
        else $error("overrun not flagged");
    chk_nodata_three: assert property (@(posedge ref_clk) disable iff (!resetn)
        setErr && st_ff.hostMode |-> st_ff.missCnt == 2'h2)
        else $error("no-data error not on third miss");
    chk_err_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_ff.overrunErr && !wrDone) |=> st_ff.overrunErr)
        else $error("error cleared without write");
    chk_full_mirror: assert property (@(posedge ref_clk) disable iff (!resetn)
        csrWord[BIT_FULL] == rxFifoNoRoom) else $error("full bit wrong");
    chk_fad_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        fadWord[31:29] == 3'h0 && fadWord[15:13] == 3'h0)
        else $error("reserved bits nonzero");
    chk_rx_scale: assert property (@(posedge ref_clk) disable iff (!resetn)
        rxBufferStartByte == 16'(st_ff.rxStart * 8)) else $error("rx start scale");
    cov_packet: cover property (@(posedge ref_clk) rxPacketDone ##1 rxPacketWaiting);
    cov_overrun: cover property (@(posedge ref_clk) setErr && !st_ff.hostMode);
    cov_nodata: cover property (@(posedge ref_clk) setErr && st_ff.hostMode);
    cov_irq: cover property (@(posedge ref_clk) $rose(irq));
endmodule

/* File: bench/uer_usb_far.sv */
// Far-side model of the USB link: turns bench commands into receive events.
// Assumes one clock; go and drain are one-cycle strobes from the bench.
`timescale 1ns/1ns
module uer_usb_far #(
    parameter int DEPTH = 2
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       go,
    input  wire logic [1:0] kind,
    input  wire logic       drain,
    output logic            rxPacketDone,
    output logic            rxPacketDropped,
    output logic            rxAttemptNoData,
    output logic            rxAttemptData,
    output logic            rxFifoNoRoom
);
    int fill;
    logic pkt;
    assign pkt = go && kind == 2'h0;
    assign rxFifoNoRoom = (fill == DEPTH);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fill <= 0;
            rxPacketDone <= 1'b0;
            rxPacketDropped <= 1'b0;
            rxAttemptNoData <= 1'b0;
            rxAttemptData <= 1'b0;
        end else begin
            rxPacketDone <= pkt && fill < DEPTH;
            // A full buffer turns an OUT packet into a drop
            rxPacketDropped <= pkt && fill == DEPTH;
            rxAttemptNoData <= go && kind == 2'h2;
            rxAttemptData <= go && kind == 2'h3;
            if (pkt && fill < DEPTH) begin
                fill <= fill + 1;
            end else if (drain && fill > 0) begin
                fill <= fill - 1;
            end
        end
    end
endmodule

/* File: bench/usb_endpoint_rx_status_fifo_map_tb.sv */
// Self-checking bench for the endpoint receive status block.
// Assumes the far-side model feeds the receive event inputs.
`timescale 1ns/1ns
module usb_endpoint_rx_status_fifo_map_tb;
    import uer_pkg::*;
    logic        ref_clk, resetn, psel, penable, pwrite, go, drain;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [1:0]  kind;
    logic        pready, pslverr, done, drop, noData, gotData, noRoom, waiting, irq;
    logic [15:0] rxStart, txStart;
    logic [PAYLOAD_W-1:0] payload;
    logic [PACKET_MULTIPLIER_W-1:0]    txn;
    int          errTotal, checked, cyc;

    uer_top u_uer_top (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxPacketDone(done), .rxPacketDropped(drop),
        .rxAttemptNoData(noData), .rxAttemptData(gotData), .rxFifoNoRoom(noRoom),
        .rxBufferStartByte(rxStart), .txBufferStartByte(txStart), .payloadSize(payload),
        .txnPerMicroframe(txn), .rxPacketWaiting(waiting), .irq(irq));
    uer_usb_far u_uer_usb_far (.ref_clk(ref_clk), .resetn(resetn), .go(go), .kind(kind),
        .drain(drain), .rxPacketDone(done), .rxPacketDropped(drop),
        .rxAttemptNoData(noData), .rxAttemptData(gotData), .rxFifoNoRoom(noRoom));

    task automatic results();
        if (errTotal == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high at a rising edge; one idle edge follows
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask

    task automatic ev(input logic [1:0] k, input logic dr);
        @(posedge ref_clk);
        go <= !dr;
        drain <= dr;
        kind <= k;
        @(posedge ref_clk);
        go <= 1'b0;
        drain <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic tReset();
        chk(irq, 1'b0);
        chk(txn, 5'h01);
        rdChk(OFS_RX_CSR, RST_WORD);
        rdChk(OFS_FIFO_ADDR, RST_WORD);
    endtask

    task automatic tFifo();
        wr(OFS_FIFO_ADDR, 32'hffff_ffff);
        rdChk(OFS_FIFO_ADDR, 32'h1fff_1fff);
        chk(rxStart, 16'hfff8);
        chk(txStart, 16'hfff8);
        wr(OFS_FIFO_ADDR, 32'h0003_0002);
        chk(rxStart, 16'h0018);
        chk(txStart, 16'h0010);
        wr(8'h40, 32'hffff_ffff);
        rdChk(8'h40, 32'h0000_0000);
        chk(pslverr, 1'b0);
    endtask

    task automatic tPayload();
        logic [4:0]  cf [5] = '{5'h00, 5'h10, 5'h0a, 5'h0c, 5'h04};
        logic [4:0]  mu [5] = '{5'd5, 5'd31, 5'd2, 5'd3, 5'd1};
        logic [10:0] mp [5] = '{11'd64, 11'h7ff, 11'd1024, 11'h7ff, 11'h3ff};
        logic [31:0] p;
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL, {27'h0, cf[i]});
            wr(OFS_RX_CSR, {16'h0, mu[i], mp[i]});
            p = (cf[i][2:1] != 2'h0 || cf[i][4]) ? mp[i] * (mu[i] + 1) : mp[i];
            chk(payload, p);
            rdChk(OFS_PAYLOAD, p);
            chk(txn, (cf[i][3] && cf[i][2:1] != 2'h0) ? mu[i] : 5'h01);
            rdChk(OFS_RX_CSR, {16'h0, mu[i], mp[i]});
        end
    endtask

    task automatic tReady();
        wr(OFS_CTRL, 32'h0);
        wr(OFS_RX_CSR, 32'h0);
        wr(OFS_IRQ_MASK, 32'h1);
        ev(2'h0, 1'b0);
        chk(waiting, 1'b1);
        chk(irq, 1'b1);
        rdChk(OFS_RX_CSR, 32'h0001_0000);
        ev(2'h0, 1'b1);
        wr(OFS_RX_CSR, 32'h0);
        chk(waiting, 1'b0);
        rdChk(OFS_IRQ_STAT, 32'h1);
        chk(irq, 1'b0);
        wr(OFS_RX_CSR, 32'h0007_0000);
        rdChk(OFS_RX_CSR, 32'h0);
        wr(OFS_IRQ_MASK, 32'h0);
        ev(2'h0, 1'b0);
        chk(waiting, 1'b1);
        chk(irq, 1'b0);
        ev(2'h0, 1'b1);
        wr(OFS_RX_CSR, 32'h0);
        rdChk(OFS_IRQ_STAT, 32'h1);
    endtask

    task automatic tOverrun();
        wr(OFS_CTRL, 32'h4);
        ev(2'h0, 1'b0);
        ev(2'h0, 1'b0);
        rdChk(OFS_RX_CSR, 32'h0003_0000);
        ev(2'h0, 1'b0);
        rdChk(OFS_RX_CSR, 32'h0007_0000);
        ev(2'h0, 1'b1);
        rdChk(OFS_RX_CSR, 32'h0005_0000);
        wr(OFS_RX_CSR, 32'h0);
        rdChk(OFS_RX_CSR, 32'h0);
        wr(OFS_CTRL, 32'h0);
        ev(2'h0, 1'b0);
        ev(2'h0, 1'b0);
        rdChk(OFS_RX_CSR, 32'h0003_0000);
        ev(2'h0, 1'b1);
        ev(2'h0, 1'b1);
        wr(OFS_RX_CSR, 32'h0);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
    endtask

    task automatic tNoData();
        wr(OFS_CTRL, 32'h1);
        wr(OFS_IRQ_MASK, 32'h2);
        ev(2'h2, 1'b0);
        ev(2'h2, 1'b0);
        ev(2'h3, 1'b0);
        ev(2'h2, 1'b0);
        ev(2'h2, 1'b0);
        rdChk(OFS_RX_CSR, 32'h0);
        chk(irq, 1'b0);
        ev(2'h2, 1'b0);
        rdChk(OFS_RX_CSR, 32'h0004_0000);
        chk(irq, 1'b1);
        rdChk(OFS_IRQ_STAT, 32'h2);
        wr(OFS_RX_CSR, 32'h0);
        rdChk(OFS_RX_CSR, 32'h0);
        wr(OFS_CTRL, 32'h5);
        repeat (3) ev(2'h2, 1'b0);
        rdChk(OFS_RX_CSR, 32'h0);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Cuts a hang short well beyond the few hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errTotal++;
            results();
        end
    end

    initial begin
        {resetn, psel, penable, pwrite, go, drain} = 6'h00;
        {paddr, pwdata, kind, errTotal, checked, cyc} = '0;
        pstrb = 4'hf;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        tReset();
        tFifo();
        tPayload();
        tReady();
        tOverrun();
        tNoData();
        results();
    end
endmodule
